// *** src/ocd_serial_ctrl.sv ***
`timescale 1ns/10ps
module ocd_serial_ctrl (
  // Clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     reset_in,
  // Serial bus pins
  input  wire ocd_pkg::ocd_spi_pins_type spi_in,
  output logic                          miso_out,
  output logic                          miso_oe_n_out,
  // Reset and parallel drive pins
  input  wire logic                     drv_reset_n_in,
  input  wire logic                     parallel_drive_a_n_in,
  input  wire logic                     parallel_drive_b_n_in,
  // Output stage sense
  input  wire ocd_pkg::ocd_sense_type   sense_in,
  // Channel drives
  output logic                          switch_out_a_out,
  output logic                          switch_out_b_out,
  output logic [5:0]                    switch_out_rest_out
);
  import ocd_pkg::*;

  //****************************************
  // Pin synchronisers
  //****************************************
  logic [5:0]    pin_meta;
  logic [5:0]    pin_sync;
  ocd_sense_type sense_meta;
  ocd_sense_type sense_sync;
  logic          cs_n_s;
  logic          sck_s;
  logic          mosi_s;
  logic          pin_reset;
  logic          par_a_on;
  logic          par_b_on;

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      // Idle levels: deselected, clock low, reset and drive pins inactive
      pin_meta   <= 6'h27;
      pin_sync   <= 6'h27;
      sense_meta <= '0;
      sense_sync <= '0;
    end
    else
    begin
      pin_meta   <= {spi_in.cs_n, spi_in.sck, spi_in.mosi, drv_reset_n_in,
                     parallel_drive_a_n_in, parallel_drive_b_n_in};
      pin_sync   <= pin_meta;
      sense_meta <= sense_in;
      sense_sync <= sense_meta;
    end
  end

  assign cs_n_s    = pin_sync[5];
  assign sck_s     = pin_sync[4];
  assign mosi_s    = pin_sync[3];
  assign pin_reset = ~pin_sync[2];
  assign par_a_on  = ~pin_sync[1];
  assign par_b_on  = ~pin_sync[0];

  //****************************************
  // Serial shift logic
  //****************************************
  logic       cs_prev;
  logic       sck_prev;
  logic [7:0] rx_sr;
  logic [7:0] tx_sr;
  logic [2:0] bit_cnt;
  logic       byte_seen;
  logic [7:0] channel_ctl_bits;
  logic       next_cs_prev;
  logic       next_sck_prev;
  logic [7:0] next_rx_sr;
  logic [7:0] next_tx_sr;
  logic [2:0] next_bit_cnt;
  logic       next_byte_seen;
  logic [7:0] next_channel_ctl_bits;
  logic       next_miso;
  logic       next_miso_oe_n;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic [7:0] channel_fault_bits;
  logic [7:0] drive;

  always_comb
  begin
    cs_fall  = cs_prev & ~cs_n_s;
    cs_rise  = ~cs_prev & cs_n_s;
    sck_rise = ~sck_prev & sck_s;
    sck_fall = sck_prev & ~sck_s;
    next_cs_prev          = cs_n_s;
    next_sck_prev         = sck_s;
    next_rx_sr            = rx_sr;
    next_tx_sr            = tx_sr;
    next_bit_cnt          = bit_cnt;
    next_byte_seen        = byte_seen;
    next_channel_ctl_bits = channel_ctl_bits;
    next_miso             = miso_out;
    next_miso_oe_n        = miso_oe_n_out;
    if (cs_fall)
    begin
      next_tx_sr     = chan_to_serial(channel_fault_bits);
      next_bit_cnt   = BIT_CNT_RESET;
      next_byte_seen = 1'b0;
      next_miso_oe_n = 1'b0;
    end
    else if (cs_rise)
    begin
      next_miso_oe_n = 1'b1;
      // A torn byte would scramble the channel map, so drop it
      if (byte_seen && bit_cnt == BIT_CNT_RESET)
        next_channel_ctl_bits = serial_to_chan(rx_sr);
    end
    else if (!cs_n_s)
    begin
      if (sck_rise)
      begin
        next_miso  = tx_sr[7];
        next_tx_sr = {tx_sr[6:0], 1'b0};
      end
      if (sck_fall)
      begin
        next_rx_sr   = {rx_sr[6:0], mosi_s};
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == BIT_CNT_LAST)
          next_byte_seen = 1'b1;
      end
    end
    if (pin_reset)
      next_channel_ctl_bits = CTL_RESET;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      cs_prev          <= 1'b1;
      sck_prev         <= 1'b0;
      rx_sr            <= 8'h00;
      tx_sr            <= 8'h00;
      bit_cnt          <= BIT_CNT_RESET;
      byte_seen        <= 1'b0;
      channel_ctl_bits <= CTL_RESET;
      miso_out         <= 1'b0;
      miso_oe_n_out    <= 1'b1;
    end
    else
    begin
      cs_prev          <= next_cs_prev;
      sck_prev         <= next_sck_prev;
      rx_sr            <= next_rx_sr;
      tx_sr            <= next_tx_sr;
      bit_cnt          <= next_bit_cnt;
      byte_seen        <= next_byte_seen;
      channel_ctl_bits <= next_channel_ctl_bits;
      miso_out         <= next_miso;
      miso_oe_n_out    <= next_miso_oe_n;
    end
  end

  //****************************************
  // Channels
  //****************************************
  for (genvar i = 0; i < NUM_CHANNELS; i++)
  begin : g_chan
    ocd_channel_fault #(
      .LATCH_OC (i < NUM_LATCHING),
      .HAS_PAR  (i < NUM_PARALLEL)
    ) u_fault (
      .ref_clk_in     (ref_clk_in),
      .reset_in       (reset_in),
      .ctl_bit_in     (channel_ctl_bits[i]),
      .par_on_in      ((i == 0) ? par_a_on : ((i == 1) ? par_b_on : 1'b0)),
      .pin_reset_in   (pin_reset),
      .overcurrent_in (sense_sync.overcurrent[i]),
      .overtemp_in    (sense_sync.overtemp[i]),
      .open_load_in   (sense_sync.open_load[i]),
      .drive_out      (drive[i]),
      .fault_bit_out  (channel_fault_bits[i])
    );
  end

  assign switch_out_a_out    = drive[0];
  assign switch_out_b_out    = drive[1];
  assign switch_out_rest_out = drive[7:2];

  //****************************************
  // Assertions
  //****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_commit_byte: assert property (
    cs_rise && byte_seen && bit_cnt == BIT_CNT_RESET && !pin_reset
    |=> channel_ctl_bits == serial_to_chan($past(rx_sr)))
    else $error("control byte not committed in channel order");
  a_partial_drop: assert property (
    cs_rise && bit_cnt != BIT_CNT_RESET && !pin_reset |=> $stable(channel_ctl_bits))
    else $error("partial byte reached channel latches");
  a_status_load: assert property (
    cs_fall |=> tx_sr == chan_to_serial($past(channel_fault_bits)))
    else $error("status not loaded in channel order");
  a_miso_float: assert property (
    cs_n_s && cs_prev |=> miso_oe_n_out && $stable(rx_sr) && $stable(bit_cnt))
    else $error("serial port active while deselected");
  a_reset_clears: assert property (
    pin_reset |=> channel_ctl_bits == CTL_RESET && drive == 8'h00)
    else $error("reset pin did not force channels off");
  a_par_drive: assert property (
    par_a_on && !pin_reset && !g_chan[0].u_fault.fault_latch
    |=> switch_out_a_out)
    else $error("parallel drive did not switch channel 0 on");
  a_miso_shift: assert property (
    !cs_n_s && !cs_fall && sck_rise |=> miso_out == $past(tx_sr[7]))
    else $error("serial output not updated on clock rise");
  c_byte_commit: cover property (cs_rise && byte_seen && bit_cnt == BIT_CNT_RESET);
  c_partial: cover property (cs_rise && bit_cnt != BIT_CNT_RESET);
  c_two_bytes: cover property (!cs_n_s && sck_fall && bit_cnt == BIT_CNT_LAST && byte_seen);
endmodule

// *** common/ocd_pkg.sv ***
// What this block does
// - Channels 0,1 on when control bit set or parallel input low.
// - Channels 2 to 7 follow their latched control bit.
// - Serial bits MSB to LSB map to channels 1,3,5,7,0,2,4,6.
// - Returned fault byte uses the same bit positions as control byte.
// - Overcurrent on channels 0 to 5 latches that channel off.
// - Channels 6,7 limit current and latch off only on overtemperature.
// - Each channel has own output latch, fault latch and fault bit.
// - All channels sample output state for serial read back.
// - Overcurrent must persist 0.2 to 12 us before shutdown.
// - Fault detection ignored 15 to 50 us after parallel input change.
// - Open-load fault flagged while output comparator is below reference.
// - Select fall loads status; select rise transfers shifted byte.
// - Latches update only after a nonzero multiple of 8 clocks.
// - Clock idles low; input taken on falling, output changes rising.
// - Reset pin low forces all channels off, clears fault latches.
package ocd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned QUAL_MIN_NS   = 200;
  localparam int unsigned QUAL_MAX_NS   = 12000;
  localparam int unsigned BLANK_MIN_NS  = 15000;
  localparam int unsigned BLANK_MAX_NS  = 50000;
  // Least times round up to whole cycles
  localparam int unsigned QUAL_CYCLES   = (QUAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYCLES  = (BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned NUM_CHANNELS  = 8;
  localparam int unsigned NUM_LATCHING  = 6;
  localparam int unsigned NUM_PARALLEL  = 2;
  localparam int unsigned BYTE_BITS     = 8;

  localparam logic [7:0] CTL_RESET      = 8'h00;
  localparam logic [2:0] BIT_CNT_RESET  = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST   = 3'h7;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } ocd_spi_pins_type;

  typedef struct packed {
    logic [7:0] overcurrent;
    logic [7:0] overtemp;
    logic [7:0] open_load;
  } ocd_sense_type;

  // Output bit c is the serial bit that carries channel c
  function automatic logic [7:0] serial_to_chan(input logic [7:0] ser);
    serial_to_chan = {ser[4], ser[0], ser[5], ser[1], ser[6], ser[2], ser[7], ser[3]};
  endfunction

  function automatic logic [7:0] chan_to_serial(input logic [7:0] ch);
    chan_to_serial = {ch[1], ch[3], ch[5], ch[7], ch[0], ch[2], ch[4], ch[6]};
  endfunction

endpackage

// *** src/ocd_channel_fault.sv ***
`timescale 1ns/10ps
module ocd_channel_fault #(
  parameter bit LATCH_OC = 1'b1,
  parameter bit HAS_PAR  = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  // Control
  input  wire logic ctl_bit_in,
  input  wire logic par_on_in,
  input  wire logic pin_reset_in,
  // Sense, already synchronised
  input  wire logic overcurrent_in,
  input  wire logic overtemp_in,
  input  wire logic open_load_in,
  // Results
  output logic      drive_out,
  output logic      fault_bit_out
);
  import ocd_pkg::*;

  logic       fault_latch;
  logic       par_prev;
  logic [3:0] qual_cnt;
  logic [9:0] blank_cnt;
  logic       next_fault_latch;
  logic       next_par_prev;
  logic [3:0] next_qual_cnt;
  logic [9:0] next_blank_cnt;
  logic       next_drive;
  logic       next_fault_bit;
  logic       on_cmd;
  logic       blank;
  logic       par_edge;
  logic       oc_cond;
  logic       trip;

  always_comb
  begin
    on_cmd   = ctl_bit_in | (HAS_PAR & par_on_in);
    par_edge = HAS_PAR & (par_on_in != par_prev);
    // The edge cycle itself is blanked so a trip cannot slip in before the count loads
    blank    = HAS_PAR & (par_edge | (blank_cnt != 10'h000));
    oc_cond  = LATCH_OC & on_cmd & overcurrent_in & ~blank;
    // Lamp channels rely on analog current limit, latch only when hot
    trip     = LATCH_OC ? (oc_cond && qual_cnt == 4'(QUAL_CYCLES - 1))
                        : (overtemp_in & ~blank);
    next_par_prev  = par_on_in;
    next_blank_cnt = par_edge ? 10'(BLANK_CYCLES)
                   : (blank ? blank_cnt - 10'h001 : 10'h000);
    next_qual_cnt  = (oc_cond && qual_cnt != 4'(QUAL_CYCLES - 1)) ? qual_cnt + 4'h1
                   : (oc_cond ? qual_cnt : 4'h0);
    // Set beats the off-clear so a fault in the clearing cycle survives
    if (pin_reset_in)
      next_fault_latch = 1'b0;
    else if (trip)
      next_fault_latch = 1'b1;
    else if (!on_cmd)
      next_fault_latch = 1'b0;
    else
      next_fault_latch = fault_latch;
    next_drive     = on_cmd & ~fault_latch & ~pin_reset_in;
    next_fault_bit = fault_latch | (open_load_in & ~blank);
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      fault_latch   <= 1'b0;
      par_prev      <= 1'b0;
      qual_cnt      <= 4'h0;
      blank_cnt     <= 10'h000;
      drive_out     <= 1'b0;
      fault_bit_out <= 1'b0;
    end
    else
    begin
      fault_latch   <= next_fault_latch;
      par_prev      <= next_par_prev;
      qual_cnt      <= next_qual_cnt;
      blank_cnt     <= next_blank_cnt;
      drive_out     <= next_drive;
      fault_bit_out <= next_fault_bit;
    end
  end

  //****************************************
  // Assertions
  //****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_oc_trip_delay: assert property (
    (oc_cond && !pin_reset_in)[*8] ##1 (oc_cond && !pin_reset_in)[*2] |=> fault_latch)
    else $error("overcurrent not latched after qualifying delay");
  a_oc_not_early: assert property (
    (LATCH_OC && !fault_latch && !oc_cond) ##1 oc_cond[*8] |=> !fault_latch)
    else $error("overcurrent latched before qualifying delay");
  a_blank_window: assert property (
    par_edge && !fault_latch |=> !fault_latch[*8])
    else $error("fault latched inside blanking window");
  a_lamp_no_oc: assert property (
    !LATCH_OC && !overtemp_in && !fault_latch |=> !fault_latch)
    else $error("lamp channel latched without overtemperature");
  a_pin_reset_off: assert property (
    pin_reset_in |=> !drive_out && !fault_latch)
    else $error("channel not forced off by reset pin");
  a_latch_blocks: assert property (
    fault_latch |=> !drive_out)
    else $error("latched-off channel still driven");
  c_oc_trip: cover property (LATCH_OC && $rose(fault_latch));
  c_rearm: cover property ($fell(fault_latch) && !pin_reset_in);
endmodule

// *** verif/ocd_spi_master_model.sv ***
`timescale 1ns/10ps
module ocd_spi_master_model (
  // Clock
  input  wire logic                 ref_clk_in,
  // Serial bus
  output ocd_pkg::ocd_spi_pins_type spi_out,
  input  wire logic                 miso_in
);
  import ocd_pkg::*;
  // ****************
  // Master behaviour
  // ****************
  initial spi_out = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};

  // Released data line toggles so a stale bit is never trusted
  always @(posedge ref_clk_in)
    if (spi_out.sck == 1'b0)
      spi_out.mosi <= ~spi_out.mosi;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // Half periods of 8 clocks, well above the synchroniser and edge finder delay
  task automatic xfer(input logic [15:0] tx, input int nbits, input bit sel,
                      output logic [7:0] rx);
    rx = 8'h00;
    spi_out.cs_n = ~sel;
    wait_clk(8);
    for (int i = nbits - 1; i >= 0; i--)
    begin
      spi_out.sck  = 1'b1;
      spi_out.mosi = tx[i];
      wait_clk(8);
      rx = {rx[6:0], miso_in};
      spi_out.sck = 1'b0;
      wait_clk(8);
    end
    spi_out.cs_n = 1'b1;
    wait_clk(8);
  endtask
endmodule

// *** verif/ocd_serial_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module ocd_serial_ctrl_tb_top;
  import ocd_pkg::*;
  logic             ref_clk_in;
  logic             reset_in;
  logic             drv_reset_n;
  logic             par_a_n;
  logic             par_b_n;
  ocd_spi_pins_type spi;
  ocd_sense_type    sense;
  logic             miso;
  logic             miso_oe_n;
  logic             sw_a;
  logic             sw_b;
  logic [5:0]       sw_rest;
  wire logic        miso_w;
  logic [7:0]       rx;
  logic [7:0]       ser;
  int               fails;
  int               tests_run;
  int               cycles;

  // Undriven pin shows the inverse so a stale bit is never trusted
  assign miso_w = miso_oe_n ? ~miso : miso;

  ocd_serial_ctrl dut (
    .ref_clk_in            (ref_clk_in),
    .reset_in              (reset_in),
    .spi_in                (spi),
    .miso_out              (miso),
    .miso_oe_n_out         (miso_oe_n),
    .drv_reset_n_in        (drv_reset_n),
    .parallel_drive_a_n_in (par_a_n),
    .parallel_drive_b_n_in (par_b_n),
    .sense_in              (sense),
    .switch_out_a_out      (sw_a),
    .switch_out_b_out      (sw_b),
    .switch_out_rest_out   (sw_rest)
  );

  ocd_spi_master_model m (
    .ref_clk_in (ref_clk_in),
    .spi_out    (spi),
    .miso_in    (miso_w)
  );

  // ***************
  // Helpers
  // ***************
  function automatic logic [7:0] ser2ch(input logic [7:0] s);
    int order [8] = '{1, 3, 5, 7, 0, 2, 4, 6};
    logic [7:0] c;
    for (int k = 0; k < 8; k++)
      c[order[k]] = s[7 - k];
    return c;
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] s);
    m.xfer({8'h00, s}, 8, 1'b1, rx);
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // Run takes about 4200 clocks
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // ***************
  // Scenarios
  // ***************
  initial
  begin
    reset_in = 1'b1;
    drv_reset_n = 1'b1;
    par_a_n = 1'b1;
    par_b_n = 1'b1;
    sense = '0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(66));
    clk(4);
    reset_in = 1'b0;
    check("drives", 8'h00, {sw_rest, sw_b, sw_a});
    check("miso enable", 8'h01, {7'h00, miso_oe_n});
    clk(3);
    for (int i = 0; i < 8; i++)
    begin
      ser = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : (i == 2) ? 8'h08 : 8'($urandom);
      wr(ser);
      check("drives", ser2ch(ser), {sw_rest, sw_b, sw_a});
    end
    m.xfer({8'h00, ~ser}, 7, 1'b1, rx);
    check("short frame", ser2ch(ser), {sw_rest, sw_b, sw_a});
    m.xfer({8'h00, ~ser}, 8, 1'b0, rx);
    check("deselected", ser2ch(ser), {sw_rest, sw_b, sw_a});
    m.xfer(16'h5a3c, 16, 1'b1, rx);
    check("two bytes", ser2ch(8'h3c), {sw_rest, sw_b, sw_a});
    // Parallel inputs
    wr(8'h00);
    par_b_n = 1'b0;
    clk(6);
    check("par b", 8'h02, {sw_rest, sw_b, sw_a});
    par_b_n = 1'b1;
    par_a_n = 1'b0;
    clk(6);
    check("par a", 8'h01, {sw_rest, sw_b, sw_a});
    par_a_n = 1'b1;
    wr(8'h08);
    sense.overcurrent[0] = 1'b1;
    clk(20);
    check("blanked", 8'h01, {sw_rest, sw_b, sw_a});
    sense.overcurrent[0] = 1'b0;
    clk(800);
    sense.overcurrent[0] = 1'b1;
    clk(20);
    check("ch0 trip", 8'h00, {sw_rest, sw_b, sw_a});
    sense.overcurrent[0] = 1'b0;
    // Qualifying time and re-arm
    wr(8'h04);
    sense.overcurrent[2] = 1'b1;
    clk(5);
    sense.overcurrent[2] = 1'b0;
    clk(5);
    check("glitch", 8'h04, {sw_rest, sw_b, sw_a});
    sense.overcurrent[2] = 1'b1;
    clk(20);
    sense.overcurrent[2] = 1'b0;
    check("ch2 trip", 8'h00, {sw_rest, sw_b, sw_a});
    m.xfer({8'h00, 8'h04}, 8, 1'b1, rx);
    check("status", 8'h04, rx);
    check("stays off", 8'h00, {sw_rest, sw_b, sw_a});
    wr(8'h00);
    wr(8'h04);
    check("re-armed", 8'h04, {sw_rest, sw_b, sw_a});
    // Lamp channels
    wr(8'h11);
    sense.overcurrent[7:6] = 2'b11;
    clk(30);
    sense.overcurrent[7:6] = 2'b00;
    check("lamp current", 8'hc0, {sw_rest, sw_b, sw_a});
    sense.overtemp[7] = 1'b1;
    clk(6);
    sense.overtemp[7] = 1'b0;
    check("lamp temp", 8'h40, {sw_rest, sw_b, sw_a});
    m.xfer({8'h00, 8'h11}, 8, 1'b1, rx);
    check("lamp status", 8'h10, rx);
    // Open load
    wr(8'h00);
    sense.open_load[5] = 1'b1;
    clk(6);
    m.xfer(16'h0000, 8, 1'b1, rx);
    sense.open_load[5] = 1'b0;
    check("open load", 8'h20, rx);
    // Reset pin
    wr(8'hff);
    check("all on", 8'hff, {sw_rest, sw_b, sw_a});
    drv_reset_n = 1'b0;
    clk(6);
    check("pin reset", 8'h00, {sw_rest, sw_b, sw_a});
    drv_reset_n = 1'b1;
    clk(6);
    check("after reset", 8'h00, {sw_rest, sw_b, sw_a});
    check("miso idle", 8'h01, {7'h00, miso_oe_n});
    tally_and_finish();
  end
endmodule
